// [logic/tpgd_gate_ctrl.sv]
/*
  Three-phase gate drive control: power-up sequencing, sleep, command
  decode with dead time, blanking of the drain-source monitor and latched
  fault handling with an open-drain fault flag.
  Assumes all pin inputs are asynchronous to core_clk and that analog
  comparators deliver digital levels; rst_n reflects supply lockout.
*/
// Summary of operation
// - Power-up starts only while the input supply is above lockout.
// - Wait for gate supply good before becoming functional.
// - After power-up starts, gates stay off for the power-up delay.
// - Sleep input low disables everything and ignores all other inputs.
// - Leaving sleep restarts the full power-up sequence.
// - Low only turns low side on, high only high side; otherwise both off.
// - Positive dead time between one side off and the other side on.
// - One dead time for all phases, 70 ns per kilohm of setting.
// - Grounded dead-time setting gives the 130 ns minimum.
// - Drain-source drop over reference turns all gates off, latched, flag set.
// - Shunt over-current latches a fault disabling everything.
// - Drain-source monitor ignored for a blanking interval after switching.
// - Supply lockout disables and resets logic; recovery restarts power-up.
// - Gate supply loss after power-up latches a fault and sets the flag.
// - Over-temperature latches a fault disabling everything.
// - Fault output pulled low while a fault holds, released when it clears.
`timescale 1ns/1ps
module tpgd_gate_ctrl #(
  parameter int PWRUP_CYC  = tpgd_pkg::PWRUP_CYCLES,
  parameter int BLANK_CYC  = tpgd_pkg::BLANK_CYCLES,
  parameter int PHASES     = tpgd_pkg::NUM_PHASES
) (
  input  wire logic                                       core_clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       sleep_request_low,
  input  wire logic                                       supply_in_ok,
  input  wire logic                                       gate_supply_ok,
  input  wire tpgd_pkg::tpgd_pair_t [tpgd_pkg::NUM_PHASES-1:0] phase_cmd,
  input  wire logic [tpgd_pkg::NUM_PHASES-1:0]            vds_over_ref,
  input  wire logic                                       shunt_sense_over,
  input  wire logic                                       over_temp,
  input  wire logic [tpgd_pkg::DT_KOHM_W-1:0]             deadtime_set,
  output tpgd_pkg::tpgd_pair_t [tpgd_pkg::NUM_PHASES-1:0] gate_on,
  output logic                                            fault_flag_out_o,
  output logic                                            fault_flag_out_oe,
  output tpgd_pkg::tpgd_fault_t                           fault_cause,
  output logic                                            functional
);
  import tpgd_pkg::*;

  initial begin
    if (PHASES != NUM_PHASES || PWRUP_CYC < 1 || PWRUP_CYC >= (1 << 21) || BLANK_CYC < 1 ||
        BLANK_CYC >= (1 << CNT_W)) begin
      $error("tpgd_gate_ctrl: unsupported parameter value");
    end
  end

  // ============================================================
  // Input synchronisers: three stages, change accepted when 2 and 3 agree
  localparam int SYNC_W = 2 * NUM_PHASES + NUM_PHASES + 5;
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_s1;
  logic [SYNC_W-1:0] sync_s2;
  logic [SYNC_W-1:0] sync_s3;
  logic [SYNC_W-1:0] filt;
  assign raw_in = {phase_cmd, vds_over_ref, shunt_sense_over, over_temp,
                   gate_supply_ok, supply_in_ok, sleep_request_low};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1 <= '0;
      sync_s2 <= '0;
      sync_s3 <= '0;
      filt    <= '0;
    end else begin
      sync_s1 <= raw_in;
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      filt    <= (sync_s2 & sync_s3) | (filt & (sync_s2 | sync_s3));
    end
  end

  wire logic awake_s   = filt[0];
  wire logic vin_ok_s  = filt[1];
  wire logic gate_supply_ok_s = filt[2];
  wire logic otemp_s   = filt[3];
  wire logic ocp_s     = filt[4];
  wire logic [NUM_PHASES-1:0] vds_s = filt[5 +: NUM_PHASES];
  tpgd_pair_t [NUM_PHASES-1:0] cmd_s;
  assign cmd_s = filt[SYNC_W-1 -: 2*NUM_PHASES];

  // Sleep or lockout acts as a synchronous reset of the sequencer state, power-up count, latched faults and flag
  wire logic soft_reset = !awake_s || !vin_ok_s;

  // ============================================================
  // Dead-time count, one setting for all phases
  logic [CNT_W-1:0] dead_cycles;
  wire logic [CNT_W+7:0] dead_ns = (CNT_W+8)'(deadtime_set) * (CNT_W+8)'(DEAD_NS_PER_KOHM);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_cycles <= CNT_W'(DEAD_MIN_CYCLES);
    end else if (dead_ns <= (CNT_W+8)'(DEAD_MIN_NS)) begin
      dead_cycles <= CNT_W'(DEAD_MIN_CYCLES);
    end else begin
      dead_cycles <= CNT_W'((dead_ns + (CNT_W+8)'(CLK_PERIOD_NS - 1)) / (CNT_W+8)'(CLK_PERIOD_NS));
    end
  end

  // ============================================================
  // Power-up sequencer
  tpgd_state_t state;
  tpgd_state_t next_state;
  logic [20:0] pwr_cnt;
  tpgd_fault_t faults;
  wire logic any_fault = |faults;
  wire logic pwr_done  = (pwr_cnt >= 21'(PWRUP_CYC - 1));

  always_comb begin
    next_state = state;
    case (state)
      TPGD_OFF:     if (vin_ok_s && awake_s) next_state = TPGD_WAIT_GS;
      TPGD_WAIT_GS: if (gate_supply_ok_s) next_state = TPGD_DELAY;
      TPGD_DELAY:   if (pwr_done) next_state = TPGD_RUN;
      TPGD_RUN:     if (any_fault) next_state = TPGD_FAULT;
      TPGD_FAULT:   next_state = TPGD_FAULT;
      default:      next_state = TPGD_OFF;
    endcase
    if (soft_reset) next_state = TPGD_OFF;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= TPGD_OFF;
      pwr_cnt <= '0;
    end else begin
      state   <= next_state;
      pwr_cnt <= (state == TPGD_DELAY && !soft_reset) ? pwr_cnt + 21'h000001 : 21'h000000;
    end
  end

  wire logic running = (state == TPGD_RUN);
  assign functional = running;

  // ============================================================
  // Command decode, dead time and blanking per phase
  // Exactly one side asked for, else both off; the checks reuse it
  function automatic tpgd_pair_t tpgd_decode(input tpgd_pair_t cmd, input logic enable);
    tpgd_pair_t res;
    res.high_side = enable && cmd.high_side && !cmd.low_side;
    res.low_side  = enable && cmd.low_side && !cmd.high_side;
    return res;
  endfunction

  logic [NUM_PHASES-1:0] vds_valid;
  genvar p;
  generate
    for (p = 0; p < NUM_PHASES; p++) begin : g_phase
      logic [CNT_W-1:0] dead_cnt;
      logic [CNT_W-1:0] blank_cnt;
      // Decode: exactly one side asked for, else both off
      wire tpgd_pair_t want = tpgd_decode(cmd_s[p], running);
      wire logic want_hi = want.high_side;
      wire logic want_lo = want.low_side;
      wire logic dead_done = (dead_cnt >= dead_cycles);
      wire logic both_off  = !gate_on[p].high_side && !gate_on[p].low_side;
      // Turn-on only after both gates off for the full dead time
      wire logic next_hi = want_hi && (gate_on[p].high_side || (both_off && dead_done));
      wire logic next_lo = want_lo && (gate_on[p].low_side || (both_off && dead_done));
      wire logic switching = (next_hi != gate_on[p].high_side) || (next_lo != gate_on[p].low_side);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          gate_on[p] <= '0;
          dead_cnt   <= '0;
          blank_cnt  <= '0;
        end else begin
          gate_on[p].high_side <= next_hi && !any_fault;
          gate_on[p].low_side  <= next_lo && !any_fault;
          dead_cnt  <= both_off ? (dead_done ? dead_cnt : dead_cnt + 1'b1) : '0;
          blank_cnt <= switching ? CNT_W'(BLANK_CYC) : (blank_cnt != '0 ? blank_cnt - 1'b1 : '0);
        end
      end

      assign vds_valid[p] = vds_s[p] && (blank_cnt == '0) && !switching;

      // ============================================================
      // Per-phase checks
      AST_DEAD_TIME: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(gate_on[p].high_side) |-> $past(!gate_on[p].low_side) && dead_cnt >= dead_cycles - 1'b1)
        else $error("high side turned on without dead time");

      AST_DEAD_TIME_LO: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(gate_on[p].low_side) |-> $past(!gate_on[p].high_side) && dead_cnt >= dead_cycles - 1'b1)
        else $error("low side turned on without dead time");

      AST_NO_SHOOT: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(gate_on[p].high_side && gate_on[p].low_side))
        else $error("both gates on in one phase");

      AST_GATE_CMD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (gate_on[p] != '0) |-> gate_on[p] == $past(tpgd_decode(cmd_s[p], running)))
        else $error("gate on without a matching command");

      AST_BLANK: assert property (@(posedge core_clk) disable iff (!rst_n)
        switching |=> !vds_valid[p])
        else $error("monitor not blanked after switching");

      AST_BLANK_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        switching |=> blank_cnt == CNT_W'(BLANK_CYC))
        else $error("blanking interval not restarted on switching");

      AST_VDS_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (blank_cnt != '0) |-> !vds_valid[p])
        else $error("monitor result used inside blanking interval");
    end
  endgenerate

  // ============================================================
  // Latched faults; cleared only by sleep or lockout
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      faults <= '0;
    end else if (soft_reset) begin
      faults <= '0;
    end else if (running || state == TPGD_FAULT) begin
      faults.short_trip       <= faults.short_trip | (|vds_valid);
      faults.overcurrent_trip <= faults.overcurrent_trip | ocp_s;
      faults.gate_supply_loss <= faults.gate_supply_loss | !gate_supply_ok_s;
      faults.over_temp        <= faults.over_temp | otemp_s;
    end
  end

  // Latched faults keep the flag low until sleep or lockout
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_flag_out_oe <= 1'b0;
      fault_cause       <= '0;
    end else begin
      fault_flag_out_oe <= any_fault && !soft_reset;
      fault_cause       <= faults;
    end
  end
  assign fault_flag_out_o = 1'b0;

  // ============================================================
  // Sequencer and protection checks
  AST_SLEEP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    soft_reset |=> ##1 (gate_on == '0))
    else $error("gates on while asleep or locked out");

  AST_PWRUP_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state == TPGD_DELAY) |-> (state == TPGD_DELAY && gate_on == '0) [*8])
    else $error("gates active during power-up delay");

  AST_DELAY_STAY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_DELAY && !pwr_done && !soft_reset) |=> state == TPGD_DELAY)
    else $error("power-up delay cut short");

  AST_PWRUP_END: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_DELAY && pwr_done && !soft_reset) |=> running)
    else $error("power-up delay did not end in run");

  AST_OFF_GATES: assert property (@(posedge core_clk) disable iff (!rst_n)
    !running |=> gate_on == '0)
    else $error("gates on outside run");

  AST_GS_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_WAIT_GS && !gate_supply_ok_s && !soft_reset) |=> state == TPGD_WAIT_GS)
    else $error("left gate supply wait without supply good");

  AST_GS_ENTRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_WAIT_GS && gate_supply_ok_s && !soft_reset) |=> state == TPGD_DELAY)
    else $error("gate supply good did not start the delay");

  AST_START_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_OFF && !vin_ok_s) |=> state == TPGD_OFF)
    else $error("power-up started under lockout");

  AST_WAKE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_OFF && !soft_reset) |=> state == TPGD_WAIT_GS)
    else $error("power-up not started on wake");

  AST_RUN_SUPPLY: assert property (@(posedge core_clk) disable iff (!rst_n)
    running |-> $past(!soft_reset))
    else $error("run entered under sleep or lockout");

  AST_SLEEP_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    soft_reset |=> faults == '0)
    else $error("faults kept through sleep or lockout");

  AST_DEAD_FLOOR: assert property (@(posedge core_clk) disable iff (!rst_n)
    dead_cycles >= CNT_W'(DEAD_MIN_CYCLES))
    else $error("dead time below the minimum");

  AST_FAULT_KILL: assert property (@(posedge core_clk) disable iff (!rst_n)
    (any_fault && !soft_reset) |=> (gate_on == '0) && fault_flag_out_oe)
    else $error("fault did not stop gates and set flag");

  AST_CAUSE_GATES: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault_cause != '0) |-> gate_on == '0)
    else $error("gates on while a fault cause stands");

  AST_SHORT_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((running || state == TPGD_FAULT) && (|vds_valid) && !soft_reset) |=> faults.short_trip)
    else $error("short not latched");

  AST_FAULT_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (any_fault && !soft_reset) |=> any_fault || $past(soft_reset))
    else $error("fault cleared without sleep or lockout");

  AST_OCP_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && ocp_s && !soft_reset) |=> faults.overcurrent_trip)
    else $error("over-current not latched");

  AST_FAULT_ENTRY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && any_fault && !soft_reset) |=> state == TPGD_FAULT)
    else $error("fault did not leave run");

  AST_FAULT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == TPGD_FAULT && !soft_reset) |=> state == TPGD_FAULT)
    else $error("fault state left without sleep or lockout");

  AST_GS_LOSS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && !gate_supply_ok_s && !soft_reset) |=> faults.gate_supply_loss)
    else $error("gate supply loss not latched");

  AST_OTEMP_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && otemp_s && !soft_reset) |=> faults.over_temp)
    else $error("over-temperature not latched");

  AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (any_fault && !soft_reset) |=> fault_flag_out_oe)
    else $error("fault flag not pulled low");

  AST_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    !any_fault |=> !fault_flag_out_oe)
    else $error("fault flag held without a fault");

  AST_CAUSE_MIRROR: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_cause == $past(faults))
    else $error("reported cause differs from latched faults");

endmodule

// [logic/tpgd_pkg.sv]
/*
  Package for the three-phase gate drive control block: timing constants,
  state encoding and the per-phase command carrier.
  Assumes a 25 MHz core clock.
*/
package tpgd_pkg;

  // ============================================================
  // Clock and timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PWRUP_MIN_US    = 1000;
  localparam int PWRUP_MAX_US    = 2000;
  // Least time rounds up; 1 ms sits inside the 1..2 ms window
  localparam int PWRUP_CYCLES    = (PWRUP_MIN_US * (CLK_HZ / 1_000_000));
  localparam int DEAD_NS_PER_KOHM = 70;
  localparam int DEAD_MIN_NS     = 130;
  localparam int DEAD_MIN_CYCLES = (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_NS        = 1000;
  localparam int BLANK_CYCLES    = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_PHASES      = 3;
  localparam int DT_KOHM_W       = 8;
  localparam int CNT_W           = 16;
  localparam int SYNC_STAGES     = 3;

  // ============================================================
  // Power-up sequencer states
  typedef enum logic [4:0] {
    TPGD_OFF     = 5'h01,
    TPGD_WAIT_GS = 5'h02,
    TPGD_DELAY   = 5'h04,
    TPGD_RUN     = 5'h08,
    TPGD_FAULT   = 5'h10
  } tpgd_state_t;

  // ============================================================
  // Per-phase command and gate pair
  typedef struct packed {
    logic high_side;
    logic low_side;
  } tpgd_pair_t;

  // Latched fault causes
  typedef struct packed {
    logic short_trip;
    logic overcurrent_trip;
    logic gate_supply_loss;
    logic over_temp;
  } tpgd_fault_t;

endpackage

// [test/tpgd_ctrl_model.sv]
/*
  Motor controller model: drives the per-phase commands and the sleep pin.
  Assumes the bench sets the wanted values; pins change at the falling edge.
*/
`timescale 1ns/1ps
module tpgd_ctrl_model (
  input  wire logic                          core_clk,
  input  wire tpgd_pkg::tpgd_pair_t [2:0]    want_cmd,
  input  wire logic                          want_run,
  output tpgd_pkg::tpgd_pair_t [2:0]         phase_cmd,
  output logic                               sleep_request_low
);
  import tpgd_pkg::*;
  // ============================================================
  // Pin drive
  // Starts low, as the pin's pull-down would leave it
  initial sleep_request_low = 1'b0;
  initial phase_cmd = '0;
  always @(negedge core_clk) begin
    phase_cmd         <= want_cmd;
    sleep_request_low <= want_run;
  end
endmodule

// [test/test_three_phase_gate_drive_control.sv]
/*
  Self-checking bench for the gate drive control block.
  Assumes the controller model on the command side; power-up is shortened.
*/
`timescale 1ns/1ps
module test_three_phase_gate_drive_control;
  import tpgd_pkg::*;
  localparam int PW = 50;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 si = 1'b0;
  logic                 gs = 1'b0;
  logic                 shunt = 1'b0;
  logic                 otemp = 1'b0;
  logic                 run = 1'b0;
  logic [2:0]           vds = 3'h0;
  logic [7:0]           dts = 8'h0;
  tpgd_pair_t [2:0]     want = '0;
  tpgd_pair_t [2:0]     phase_cmd;
  tpgd_pair_t [2:0]     gate_on;
  tpgd_fault_t          fault_cause;
  logic                 sleep_request_low;
  logic                 fl_o;
  logic                 fl_oe;
  logic                 functional;
  int                   err_count = 0;
  int                   checks = 0;
  int                   cyc = 0;
  // External pull-up on the open-drain flag
  wire fault_line = fl_oe ? fl_o : 1'b1;

  always #20 core_clk = ~core_clk;

  tpgd_ctrl_model u_tpgd_ctrl_model (.core_clk(core_clk), .want_cmd(want), .want_run(run),
    .phase_cmd(phase_cmd), .sleep_request_low(sleep_request_low));

  tpgd_gate_ctrl #(.PWRUP_CYC(PW)) u_tpgd_gate_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .sleep_request_low(sleep_request_low), .supply_in_ok(si), .gate_supply_ok(gs),
    .phase_cmd(phase_cmd), .vds_over_ref(vds), .shunt_sense_over(shunt), .over_temp(otemp),
    .deadtime_set(dts), .gate_on(gate_on), .fault_flag_out_o(fl_o), .fault_flag_out_oe(fl_oe),
    .fault_cause(fault_cause), .functional(functional));

  // ============================================================
  // Shared tasks
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task end_of_test;
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well above the roughly one thousand cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      end_of_test;
    end
  end

  task automatic pwr;
    int n;
    n = 0;
    si <= 1'b1;
    run <= 1'b1;
    gs <= 1'b1;
    tick(1);
    while (functional !== 1'b1 && n < 200) begin
      chk("gate_in_delay", gate_on, '0);
      tick(1);
      n++;
    end
    chk("pwrup_len", (n >= PW - 1 && n <= PW + 12), 1'b1);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_seq;
    want <= {3{2'b10}};
    run <= 1'b1;
    gs <= 1'b1;
    tick(60);
    chk("func_no_supply", {functional, gate_on}, '0);
    si <= 1'b1;
    gs <= 1'b0;
    tick(60);
    chk("func_no_gs", {functional, gate_on}, '0);
    pwr;
  endtask

  task automatic t_decode;
    logic [5:0] e;
    for (int i = 0; i < 4; i++) begin
      want <= {3{i[1:0]}};
      tick(30);
      e = (i == 1) ? 6'h15 : (i == 2) ? 6'h2A : 6'h0;
      chk("decode", gate_on, e);
    end
  endtask

  task automatic t_dead(int k);
    int e, n, w;
    e = (70 * k + 39) / 40;
    if (e < DEAD_MIN_CYCLES) e = DEAD_MIN_CYCLES;
    n = 0;
    w = 0;
    dts <= k[7:0];
    want <= {3{2'b01}};
    tick(30);
    want <= {3{2'b10}};
    while (gate_on[0].low_side === 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
    while (gate_on[0].high_side !== 1'b1 && n < 200) begin
      chk("no_overlap", gate_on[0].low_side, '0);
      tick(1);
      n++;
    end
    chk("dead_len", (n >= e && n <= e + 1), 1'b1);
  endtask

  task automatic t_short;
    want <= {3{2'b10}};
    tick(40);
    want <= {3{2'b01}};
    tick(5);
    // Spike lands inside the switching blank window
    vds <= 3'h1;
    tick(8);
    vds <= 3'h0;
    tick(40);
    chk("blank_cause", {fault_cause, fault_line}, 5'h01);
    vds <= 3'h2;
    tick(40);
    chk("short_cause", fault_cause, 4'h8);
    chk("short_gates", {gate_on, fault_line}, '0);
    vds <= 3'h0;
    want <= {3{2'b10}};
    tick(30);
    chk("latched_gates", gate_on, '0);
    run <= 1'b0;
    otemp <= 1'b1;
    tick(30);
    chk("sleep_clear", {functional, fault_cause, gate_on}, '0);
    chk("sleep_flag", fault_line, 1'b1);
    otemp <= 1'b0;
    pwr;
  endtask

  task automatic t_latch;
    for (int k = 0; k < 3; k++) begin
      want <= {3{2'b10}};
      shunt <= (k == 0);
      gs <= (k != 1);
      otemp <= (k == 2);
      tick(20);
      chk("cause", fault_cause, 4'h4 >> k);
      chk("gates_flag", {gate_on, fault_line}, '0);
      shunt <= 1'b0;
      gs <= 1'b1;
      otemp <= 1'b0;
      tick(20);
      chk("held", fault_cause, 4'h4 >> k);
      if (k == 1) si <= 1'b0;
      else run <= 1'b0;
      tick(20);
      chk("cleared", {functional, fault_cause}, '0);
      pwr;
    end
  endtask

  initial begin
    tick(5);
    rst_n <= 1'b1;
    t_seq;
    t_decode;
    t_dead(0);
    t_dead(3);
    t_dead(10);
    t_short;
    t_latch;
    end_of_test;
  end
endmodule
